/* rtl/tccs_defines.svh */
`ifndef TCCS_DEFINES_SVH
`define TCCS_DEFINES_SVH

// Register indices; byte address on the bus is four times the index
`define TCCS_IDX_FLAGS 6'h13
`define TCCS_IDX_CAP1_HI 6'h14
`define TCCS_IDX_CAP1_LO 6'h15
`define TCCS_IDX_CMP1_HI 6'h16
`define TCCS_IDX_CMP1_LO 6'h17
`define TCCS_IDX_CNT_HI 6'h18
`define TCCS_IDX_CNT_LO 6'h19
`define TCCS_IDX_ALT_HI 6'h1A
`define TCCS_IDX_ALT_LO 6'h1B
`define TCCS_IDX_CAP2_HI 6'h1C
`define TCCS_IDX_CAP2_LO 6'h1D
`define TCCS_IDX_CMP2_HI 6'h1E
`define TCCS_IDX_CMP2_LO 6'h1F

// Flag bit positions in timer_flags
`define TCCS_BIT_CAP1 7
`define TCCS_BIT_CMP1 6
`define TCCS_BIT_OVF 5
`define TCCS_BIT_CAP2 4
`define TCCS_BIT_CMP2 3

// Reset values
`define TCCS_FLAGS_RST 8'h00
`define TCCS_CMP_PIN_RST 1'b0

// Counter wrap points
`define TCCS_CNT_MAX 16'hFFFF
`define TCCS_CNT_ZERO 16'h0000

// AXI response codes
`define TCCS_RESP_OKAY 2'h0
`define TCCS_RESP_SLVERR 2'h2

`endif

/* rtl/tccs_pkg.sv */
package tccs_pkg;

   // Control bits that live in the timer settings register outside this block
   typedef struct packed {
      logic capture_irq_enable;
      logic compare_irq_enable;
      logic overflow_irq_enable;
      logic capture_one_edge_select;
      logic compare_one_level_bit;
   } tccs_ctl_t;

   // Valid flag plus target index of one decoded bus access
   typedef struct packed {
      logic ok;
      logic [5:0] idx;
   } tccs_dec_t;

endpackage : tccs_pkg

/* rtl/tccs_timer_capture_compare.sv */
// Functional notes
// - Status byte: capture1 bit7, compare1 bit6, overflow bit5, capture2 bit4, compare2 bit3.
// - A flag clears only after a status access then its own data register access.
// - Selected edge on capture pin one sets capture flag one; interrupt if enabled.
// - Capture flag one clears on status read then capture one low read.
// - Compare one match sets its flag; status read then compare one low clears it.
// - Counter wrap sets overflow flag; status access then counter low read clears it.
// - Falling edge on capture pin two sets flag two; cleared via status and low read.
// - Compare two match sets its flag; status read then compare two low clears it.
// - One capture interrupt enable gates both capture flags.
// - Capture one is a read-only 16-bit latch at 0x14/0x15 loaded on valid edges.
// - Captured value is one above the counter at the clock edge before the pin change.
// - Every valid edge loads the capture register whatever the flag state.
// - High byte read blocks capture loads until the low byte is read.
// - Reset leaves the capture registers unchanged.
// - Capture two is a read-only latch at 0x1c/0x1d loaded on falling edges only.
// - One compare interrupt enable gates both compare flags.
// - Compare one is checked continually; a match drives level bit one to the pin.
// - High byte write suspends compare until low byte write; bytes written independently.
// - Each match clocks the level bit to the pin, whether or not the flag is set.
// - Compare registers are plain read/write storage untouched by hardware or reset.
// - Edge select one means rising edges on capture pin one, zero means falling.
// - Level bit one gives a high pin at the next match, zero a low pin.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tccs_defines.svh"

module tccs_timer_capture_compare (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Shared counter and settings bits
   input wire logic [15:0] counter_value,
   input wire tccs_pkg::tccs_ctl_t timer_settings,
   // Pins
   input wire logic capture_pin_one,
   input wire logic capture_pin_two,
   output logic compare_pin_one,
   // Interrupt request towards the processor
   output logic timer_irq
);
   import tccs_pkg::*;

   function automatic tccs_dec_t decode(input logic [7:0] addr);
      tccs_dec_t d;
      d.idx = addr[7:2];
      d.ok = (addr[1:0] == 2'h0) && (d.idx >= `TCCS_IDX_FLAGS) && (d.idx <= `TCCS_IDX_CMP2_LO);
      return d;
   endfunction : decode

   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] arm_q;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic [7:0] cap_hi_q [2];
   logic [7:0] cap_lo_q [2];
   logic [7:0] cmp_hi_q [2];
   logic [7:0] cmp_lo_q [2];
   logic [1:0] cmp_inhibit_q;
   logic [1:0] cap_block_q;
   logic [2:0] sync_q [2];
   logic [1:0] level_q;
   logic [1:0] cap_edge;
   logic [15:0] hist_q [3];
   logic count_moved;
   logic [1:0] cmp_match;
   logic wrap;
   logic aw_v_q;
   logic w_v_q;
   logic [7:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_lane_q;
   logic do_wr;
   logic rd_fire;
   tccs_dec_t rd_dec;
   tccs_dec_t wr_dec;
   logic [7:0] rd_byte;

   // Pin synchronisers; only stages two and three are looked at
   always_ff @(posedge aclk) begin
      for (int c = 0; c < 2; c++) begin
         sync_q[c] <= {sync_q[c][1:0], (c == 0) ? capture_pin_one : capture_pin_two};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_q <= 2'h3;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (sync_q[c][1] == sync_q[c][2]) begin
               level_q[c] <= sync_q[c][2];
            end
         end
      end
   end

   always_comb begin
      cap_edge = 2'h0;
      for (int c = 0; c < 2; c++) begin
         if (sync_q[c][1] == sync_q[c][2] && sync_q[c][2] != level_q[c]) begin
            cap_edge[c] = 1'b1;
         end
      end
      // Rising when edge select is one, else falling
      cap_edge[0] = cap_edge[0] && (sync_q[0][2] == timer_settings.capture_one_edge_select);
      cap_edge[1] = cap_edge[1] && !sync_q[1][2];
   end

   // Counter history matches the synchroniser delay, so stage three holds the
   // count that stood at the edge before the pin changed
   always_ff @(posedge aclk) begin
      hist_q[0] <= counter_value;
      hist_q[1] <= hist_q[0];
      hist_q[2] <= hist_q[1];
   end

   assign count_moved = (counter_value != hist_q[0]);
   assign wrap = (hist_q[0] == `TCCS_CNT_MAX) && (counter_value == `TCCS_CNT_ZERO);

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         // One compare per count, so a held match does not refire
         cmp_match[c] = count_moved && !cmp_inhibit_q[c]
            && (counter_value == {cmp_hi_q[c], cmp_lo_q[c]});
      end
   end

   // Capture latches carry no reset so their contents survive it
   always_ff @(posedge aclk) begin
      for (int c = 0; c < 2; c++) begin
         if (cap_edge[c] && !cap_block_q[c]) begin
            {cap_hi_q[c], cap_lo_q[c]} <= hist_q[2] + 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_block_q <= 2'h0;
      end else if (rd_fire && rd_dec.ok) begin
         unique case (rd_dec.idx)
            `TCCS_IDX_CAP1_HI: cap_block_q[0] <= 1'b1;
            `TCCS_IDX_CAP1_LO: cap_block_q[0] <= 1'b0;
            `TCCS_IDX_CAP2_HI: cap_block_q[1] <= 1'b1;
            `TCCS_IDX_CAP2_LO: cap_block_q[1] <= 1'b0;
            default: ;
         endcase
      end
   end

   // Compare storage has no reset and is never touched by hardware
   always_ff @(posedge aclk) begin
      if (do_wr && w_lane_q && wr_dec.ok) begin
         unique case (wr_dec.idx)
            `TCCS_IDX_CMP1_HI: cmp_hi_q[0] <= w_data_q;
            `TCCS_IDX_CMP1_LO: cmp_lo_q[0] <= w_data_q;
            `TCCS_IDX_CMP2_HI: cmp_hi_q[1] <= w_data_q;
            `TCCS_IDX_CMP2_LO: cmp_lo_q[1] <= w_data_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_inhibit_q <= 2'h0;
      end else if (do_wr && w_lane_q && wr_dec.ok) begin
         unique case (wr_dec.idx)
            `TCCS_IDX_CMP1_HI: cmp_inhibit_q[0] <= 1'b1;
            `TCCS_IDX_CMP1_LO: cmp_inhibit_q[0] <= 1'b0;
            `TCCS_IDX_CMP2_HI: cmp_inhibit_q[1] <= 1'b1;
            `TCCS_IDX_CMP2_LO: cmp_inhibit_q[1] <= 1'b0;
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         compare_pin_one <= `TCCS_CMP_PIN_RST;
      end else if (cmp_match[0]) begin
         compare_pin_one <= timer_settings.compare_one_level_bit;
      end
   end

   // Flag set and clear
   always_comb begin
      flag_set = 8'h00;
      flag_set[`TCCS_BIT_CAP1] = cap_edge[0];
      flag_set[`TCCS_BIT_CMP1] = cmp_match[0];
      flag_set[`TCCS_BIT_OVF] = wrap;
      flag_set[`TCCS_BIT_CAP2] = cap_edge[1];
      flag_set[`TCCS_BIT_CMP2] = cmp_match[1];
      flag_clr = 8'h00;
      if (rd_fire && rd_dec.ok) begin
         unique case (rd_dec.idx)
            `TCCS_IDX_CAP1_LO: flag_clr[`TCCS_BIT_CAP1] = arm_q[`TCCS_BIT_CAP1];
            `TCCS_IDX_CMP1_LO: flag_clr[`TCCS_BIT_CMP1] = arm_q[`TCCS_BIT_CMP1];
            `TCCS_IDX_CNT_LO: flag_clr[`TCCS_BIT_OVF] = arm_q[`TCCS_BIT_OVF];
            `TCCS_IDX_CAP2_LO: flag_clr[`TCCS_BIT_CAP2] = arm_q[`TCCS_BIT_CAP2];
            `TCCS_IDX_CMP2_LO: flag_clr[`TCCS_BIT_CMP2] = arm_q[`TCCS_BIT_CMP2];
            default: ;
         endcase
      end
      flags_d = (flags_q & ~flag_clr) | flag_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= `TCCS_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // First step of a clear: a status read arms every flag then set; a status write arms the overflow flag only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm_q <= 8'h00;
      end else if (rd_fire && rd_dec.ok && rd_dec.idx == `TCCS_IDX_FLAGS) begin
         arm_q <= flags_q;
      end else if (do_wr && wr_dec.ok && wr_dec.idx == `TCCS_IDX_FLAGS) begin
         arm_q <= arm_q | (flags_q & (8'h01 << `TCCS_BIT_OVF));
      end else begin
         arm_q <= arm_q & ~flag_clr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= (timer_settings.capture_irq_enable
               && (flags_q[`TCCS_BIT_CAP1] || flags_q[`TCCS_BIT_CAP2]))
            || (timer_settings.compare_irq_enable
               && (flags_q[`TCCS_BIT_CMP1] || flags_q[`TCCS_BIT_CMP2]))
            || (timer_settings.overflow_irq_enable && flags_q[`TCCS_BIT_OVF]);
      end
   end

   // Write channel: address and data taken in either order, one write at a time
   assign wr_dec = decode(aw_addr_q);
   assign do_wr = aw_v_q && w_v_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_v_q <= 1'b0;
         w_v_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 8'h00;
         w_lane_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TCCS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_v_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_v_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_dec.ok ? `TCCS_RESP_OKAY : `TCCS_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channel: data sampled at the address handshake, side effects there too
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_dec = decode(s_axi_araddr);

   always_comb begin
      rd_byte = 8'h00;
      unique case (rd_dec.idx)
         `TCCS_IDX_FLAGS: rd_byte = flags_q & 8'hF8;
         `TCCS_IDX_CAP1_HI: rd_byte = cap_hi_q[0];
         `TCCS_IDX_CAP1_LO: rd_byte = cap_lo_q[0];
         `TCCS_IDX_CMP1_HI: rd_byte = cmp_hi_q[0];
         `TCCS_IDX_CMP1_LO: rd_byte = cmp_lo_q[0];
         `TCCS_IDX_CNT_HI, `TCCS_IDX_ALT_HI: rd_byte = counter_value[15:8];
         `TCCS_IDX_CNT_LO, `TCCS_IDX_ALT_LO: rd_byte = counter_value[7:0];
         `TCCS_IDX_CAP2_HI: rd_byte = cap_hi_q[1];
         `TCCS_IDX_CAP2_LO: rd_byte = cap_lo_q[1];
         `TCCS_IDX_CMP2_HI: rd_byte = cmp_hi_q[1];
         `TCCS_IDX_CMP2_LO: rd_byte = cmp_lo_q[1];
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TCCS_RESP_OKAY;
      end else begin
         if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_dec.ok ? rd_byte : 8'h00};
            s_axi_rresp <= rd_dec.ok ? `TCCS_RESP_OKAY : `TCCS_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Assertions
   a_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      flag_set[`TCCS_BIT_CAP1] |=> flags_q[`TCCS_BIT_CAP1])
      else $error("capture flag one lost on set");
   a_clear_needs_arm: assert property (@(posedge aclk) disable iff (!aresetn)
      ($fell(flags_q[`TCCS_BIT_OVF])) |-> $past(arm_q[`TCCS_BIT_OVF]))
      else $error("overflow flag cleared without status access");
   a_cap_one_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_fire && rd_dec.ok && rd_dec.idx == `TCCS_IDX_CAP1_LO && arm_q[7] && !cap_edge[0])
      |=> !flags_q[`TCCS_BIT_CAP1])
      else $error("capture flag one not cleared");
   a_wrap_sets_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
      (hist_q[0] == 16'hFFFF && counter_value == 16'h0000) |=> flags_q[`TCCS_BIT_OVF])
      else $error("overflow flag missed wrap");
   a_capture_value: assert property (@(posedge aclk) disable iff (!aresetn)
      (cap_edge[1] && !cap_block_q[1])
      |=> {cap_hi_q[1], cap_lo_q[1]} == $past(hist_q[2]) + 16'h0001)
      else $error("capture two value wrong");
   a_block_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_block_q[0] |=> $stable({cap_hi_q[0], cap_lo_q[0]}))
      else $error("capture one changed while blocked");
   // Watches the pin and the flag, not the match term, so a broken gate shows up
   a_inhibit_cmp: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_inhibit_q[0] |=> $stable(compare_pin_one) && !$rose(flags_q[`TCCS_BIT_CMP1]))
      else $error("compare one ran while suspended");
   a_pin_level: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_match[0] |=> compare_pin_one == $past(timer_settings.compare_one_level_bit))
      else $error("compare pin did not take level bit");
   a_irq_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      (timer_settings.capture_irq_enable && flags_q[`TCCS_BIT_CAP2]) |=> timer_irq)
      else $error("capture interrupt missing");
   a_irq_compare: assert property (@(posedge aclk) disable iff (!aresetn)
      (timer_settings.compare_irq_enable && flags_q[`TCCS_BIT_CMP2]) |=> timer_irq)
      else $error("compare interrupt missing");
   a_falling_two: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_edge[1] |-> !sync_q[1][2] && $past(level_q[1]))
      else $error("capture two on wrong edge");

endmodule : tccs_timer_capture_compare

/* verification/tccs_counter_model.sv */
`timescale 1ns/1ps
// Shared free-running counter; the bench presets or freezes it for exact capture values
module tccs_counter_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bench control
   input wire logic run,
   input wire logic load,
   input wire logic [15:0] load_value,
   // Counter towards the block
   output logic [15:0] counter_value
);
   logic [1:0] presc_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_q <= 2'h0;
         counter_value <= 16'hFFFC;
      end else if (load) begin
         presc_q <= 2'h0;
         counter_value <= load_value;
      end else if (run) begin
         presc_q <= presc_q + 2'h1;
         // Plain 16-bit roll gives the FFFF to 0000 step
         if (presc_q == 2'h3) counter_value <= counter_value + 16'h1;
      end
   end
endmodule : tccs_counter_model

/* verification/tccs_timer_capture_compare_tb.sv */
`timescale 1ns/1ps
`include "tccs_defines.svh"

module tccs_timer_capture_compare_tb;
   import tccs_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, cmp_pin, irq;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata;
   logic [15:0] cnt;
   tccs_ctl_t ctl = '0;
   logic pin1 = 1'h1, pin2 = 1'h1, run = 1'h0, load = 1'h0;
   logic [15:0] load_v = 16'h0000;
   logic [7:0] rdv;
   int err_count = 0, check_count = 0, cycles = 0;

   always #20 aclk = ~aclk;

   tccs_timer_capture_compare tccs_timer_capture_compare_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .counter_value(cnt), .timer_settings(ctl),
      .capture_pin_one(pin1), .capture_pin_two(pin2),
      .compare_pin_one(cmp_pin), .timer_irq(irq)
   );

   tccs_counter_model tccs_counter_model_i (
      .aclk(aclk), .aresetn(aresetn), .run(run), .load(load), .load_value(load_v),
      .counter_value(cnt)
   );

   task automatic complete_run;
      $display("Counts: %0d checks, %0d mismatches", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) begin
            rsp = bresp;
            bready <= 1'h0;
            break;
         end
      end
   endtask : wr

   task automatic rd(input logic [5:0] idx);
      @(posedge aclk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) begin
            rdv = rdata[7:0];
            rsp = rresp;
            rready <= 1'h0;
            break;
         end
      end
   endtask : rd

   task automatic rdc(input string what, input logic [5:0] idx, input logic [7:0] m,
                      input logic [7:0] exp);
      rd(idx);
      chk(what, exp, rdv & m);
   endtask : rdc

   task automatic set_cnt(input logic [15:0] v, input logic r);
      @(posedge aclk);
      load <= 1'h1;
      load_v <= v;
      run <= r;
      @(posedge aclk);
      load <= 1'h0;
   endtask : set_cnt

   // Ten cycles cover the three-flop sync plus the capture update
   task automatic pins(input logic p1, input logic p2);
      @(posedge aclk);
      pin1 <= p1;
      pin2 <= p2;
      cyc(10);
   endtask : pins

   task automatic irqc(input logic exp);
      cyc(2);
      chk("timer_irq", {7'h0, exp}, {7'h0, irq});
   endtask : irqc

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         $display("MISMATCH watchdog expected finish seen timeout");
         complete_run();
      end
   end

   initial begin
      cyc(3);
      aresetn <= 1'h1;
      // Pins stay high while the sync flops fill, else a false edge is seen
      cyc(3);
      rdc("flags reset", `TCCS_IDX_FLAGS, 8'hFF, `TCCS_FLAGS_RST);
      rd(6'h00);
      chk("unmapped read resp", {6'h0, `TCCS_RESP_SLVERR}, {6'h0, rsp});
      wr(6'h00, 8'h5A);
      chk("unmapped write resp", {6'h0, `TCCS_RESP_SLVERR}, {6'h0, rsp});
      // Compare values are undefined until written, so set both before the counter runs
      wr(`TCCS_IDX_CMP1_HI, 8'h80);
      wr(`TCCS_IDX_CMP1_LO, 8'h00);
      wr(`TCCS_IDX_CMP2_HI, 8'h80);
      wr(`TCCS_IDX_CMP2_LO, 8'h00);
      rdc("cmp1 hi", `TCCS_IDX_CMP1_HI, 8'hFF, 8'h80);
      $display("test reset_map done");

      set_cnt(16'hFFFE, 1'h1);
      cyc(12);
      rd(`TCCS_IDX_CNT_LO);
      rdc("overflow flag", `TCCS_IDX_FLAGS, 8'h20, 8'h20);
      @(posedge aclk) ctl.overflow_irq_enable <= 1'h1;
      irqc(1'h1);
      rd(`TCCS_IDX_ALT_LO);
      irqc(1'h1);
      rd(`TCCS_IDX_CNT_LO);
      irqc(1'h0);
      // A status write also arms the overflow clear
      set_cnt(16'hFFFE, 1'h1);
      cyc(12);
      irqc(1'h1);
      wr(`TCCS_IDX_FLAGS, 8'h00);
      rd(`TCCS_IDX_CNT_LO);
      irqc(1'h0);
      $display("test overflow done");

      @(posedge aclk) ctl <= 5'h09;
      set_cnt(16'h2000, 1'h1);
      wr(`TCCS_IDX_CMP1_HI, 8'h20);
      rd(`TCCS_IDX_FLAGS);
      wr(`TCCS_IDX_CMP1_LO, 8'h10);
      chk("pin before match", 8'h00, {7'h0, cmp_pin});
      cyc(80);
      chk("pin after match", 8'h01, {7'h0, cmp_pin});
      rd(`TCCS_IDX_CMP1_LO);
      irqc(1'h1);
      rdc("cmp1 flag", `TCCS_IDX_FLAGS, 8'h40, 8'h40);
      rd(`TCCS_IDX_CMP1_LO);
      irqc(1'h0);
      @(posedge aclk) ctl.compare_one_level_bit <= 1'h0;
      set_cnt(16'h200C, 1'h1);
      wr(`TCCS_IDX_CMP1_HI, 8'h20);
      cyc(40);
      chk("pin suspended", 8'h01, {7'h0, cmp_pin});
      irqc(1'h0);
      set_cnt(16'h2020, 1'h1);
      wr(`TCCS_IDX_CMP1_LO, 8'h24);
      cyc(40);
      chk("pin low level", 8'h00, {7'h0, cmp_pin});
      @(posedge aclk) ctl.compare_one_level_bit <= 1'h1;
      set_cnt(16'h2030, 1'h1);
      wr(`TCCS_IDX_CMP1_LO, 8'h34);
      cyc(40);
      chk("pin with flag set", 8'h01, {7'h0, cmp_pin});
      rd(`TCCS_IDX_FLAGS);
      rd(`TCCS_IDX_CMP1_LO);
      irqc(1'h0);
      $display("test compare_one done");

      set_cnt(16'h2048, 1'h1);
      wr(`TCCS_IDX_CMP2_HI, 8'h20);
      wr(`TCCS_IDX_CMP2_LO, 8'h50);
      cyc(40);
      rdc("cmp2 flag", `TCCS_IDX_FLAGS, 8'h08, 8'h08);
      irqc(1'h1);
      rd(`TCCS_IDX_CMP2_LO);
      irqc(1'h0);
      $display("test compare_two done");

      @(posedge aclk) ctl <= 5'h00;
      set_cnt(16'h1233, 1'h0);
      pins(1'h0, 1'h1);
      rdc("cap1 flag", `TCCS_IDX_FLAGS, 8'h80, 8'h80);
      chk("irq masked", 8'h00, {7'h0, irq});
      @(posedge aclk) ctl <= 5'h12;
      irqc(1'h1);
      rdc("cap1 hi", `TCCS_IDX_CAP1_HI, 8'hFF, 8'h12);
      set_cnt(16'h5677, 1'h0);
      pins(1'h1, 1'h1);
      rdc("cap1 lo blocked", `TCCS_IDX_CAP1_LO, 8'hFF, 8'h34);
      irqc(1'h0);
      set_cnt(16'h0AAA, 1'h0);
      pins(1'h0, 1'h1);
      rdc("cap1 unselected edge", `TCCS_IDX_FLAGS, 8'h80, 8'h00);
      set_cnt(16'h00FF, 1'h0);
      pins(1'h1, 1'h1);
      set_cnt(16'h01FF, 1'h0);
      pins(1'h0, 1'h1);
      pins(1'h1, 1'h1);
      rdc("cap1 latest hi", `TCCS_IDX_CAP1_HI, 8'hFF, 8'h02);
      rdc("cap1 latest lo", `TCCS_IDX_CAP1_LO, 8'hFF, 8'h00);
      @(posedge aclk) aresetn <= 1'h0;
      cyc(3);
      aresetn <= 1'h1;
      cyc(3);
      wr(`TCCS_IDX_CAP1_LO, 8'hAA);
      chk("ro write resp", {6'h0, `TCCS_RESP_OKAY}, {6'h0, rsp});
      rdc("cap1 hi kept", `TCCS_IDX_CAP1_HI, 8'hFF, 8'h02);
      rdc("cap1 lo kept", `TCCS_IDX_CAP1_LO, 8'hFF, 8'h00);
      $display("test capture_one done");

      set_cnt(16'h3343, 1'h0);
      pins(1'h1, 1'h0);
      rdc("cap2 flag", `TCCS_IDX_FLAGS, 8'h10, 8'h10);
      irqc(1'h1);
      set_cnt(16'h4443, 1'h0);
      pins(1'h1, 1'h1);
      rdc("cap2 hi", `TCCS_IDX_CAP2_HI, 8'hFF, 8'h33);
      rdc("cap2 lo", `TCCS_IDX_CAP2_LO, 8'hFF, 8'h44);
      irqc(1'h0);
      $display("test capture_two done");
      complete_run();
   end
endmodule : tccs_timer_capture_compare_tb
